// ---- hdl/psea_pack_status.sv ----
`timescale 1ns/1ns
module psea_pack_status (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic eeprom_clk,
	input wire logic ofs_cal_done,
	input wire logic ofs_cancel_en,
	input wire logic conv_pulse,
	input wire logic discharge_valid,
	input wire logic charge_fet_cmd,
	input wire logic discharge_fet_cmd,
	input wire logic over_temp,
	input wire logic lithium_pack,
	input wire logic [15:0] pack_mv,
	input wire psea_pkg::psea_limits_t limits,
	input wire psea_pkg::psea_cells_t cells,
	input wire logic full_reset_req,
	input wire logic store_req,
	input wire logic [7:0] store_addr,
	input wire logic [7:0] store_data,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	output logic rsp_valid,
	output logic rsp_known,
	output logic [15:0] rsp_data,
	output logic charge_fet_control_out,
	output logic discharge_fet_control_out,
	output logic eeprom_access_active_out,
	output logic eeprom_ack_err,
	output logic eeprom_clock_line,
	output logic eeprom_data_line_o,
	output logic eeprom_data_line_oe,
	input wire logic eeprom_data_line_i
);
	// ========================================
	// state
	psea_pkg::psea_stat_t stat_r;
	psea_pkg::psea_stat_t stat_nxt;
	psea_pkg::psea_eep_req_t req_r;
	logic [7:0] cfg_r;
	logic ofs_flag_r;
	logic act_r;
	logic boot_pend_r;
	logic req_tgl_r;
	logic done_seen_r;
	logic done_s;
	logic link_rst;
	logic link_done_tgl;
	logic link_ack_err;
	logic [7:0] link_rd_data;

	// ========================================
	// command decode
	wire is_pack = (cmd_code == psea_pkg::CMD_PACK_WORD);
	wire is_cell = (cmd_code >= psea_pkg::CMD_CELL4) && (cmd_code <= psea_pkg::CMD_CELL1);
	wire [7:0] cell_off = psea_pkg::CMD_CELL1 - cmd_code;
	wire [1:0] cell_idx = cell_off[1:0];
	wire pack_read = cmd_valid && is_pack;
	wire [15:0] word_w = {cfg_r, stat_r};
	wire [15:0] rsp_nxt = is_pack ? word_w : (is_cell ? cells[cell_idx] : psea_pkg::WORD_NONE);

	// ========================================
	// live status
	wire cell_hi = psea_pkg::cells_cmp(cells, limits.cell_hi_mv, 1'b1);
	wire cell_lo = psea_pkg::cells_cmp(cells, limits.cell_lo_mv, 1'b0);
	wire ov_now = cell_hi || (pack_mv > limits.pack_ov_mv) || over_temp;
	wire uv_now = lithium_pack && cell_lo;
	// calibration done while disabled is ignored, disable forces zero
	wire ofs_flag_nxt = ofs_cancel_en && (ofs_flag_r || ofs_cal_done);
	// a pulse in the reading cycle survives into the next read
	wire act_nxt = conv_pulse || (act_r && !pack_read);

	always_comb begin
		stat_nxt.offset_cancel_flag = ofs_flag_r;
		stat_nxt.end_of_discharge_flag = (pack_mv <= limits.eod_mv);
		stat_nxt.charge_activity_flag = act_r;
		stat_nxt.valid_discharge_flag = discharge_valid;
		stat_nxt.charge_fet_state = charge_fet_control_out;
		stat_nxt.discharge_fet_state = discharge_fet_control_out;
		stat_nxt.overvoltage_flag = ov_now;
		stat_nxt.undervoltage_flag = uv_now;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_r <= '0;
			ofs_flag_r <= 1'b0;
			act_r <= 1'b0;
			charge_fet_control_out <= 1'b0;
			discharge_fet_control_out <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			ofs_flag_r <= ofs_flag_nxt;
			act_r <= act_nxt;
			charge_fet_control_out <= charge_fet_cmd;
			discharge_fet_control_out <= discharge_fet_cmd;
		end
	end

	// ========================================
	// command answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsp_valid <= 1'b0;
			rsp_known <= 1'b0;
			rsp_data <= psea_pkg::WORD_NONE;
		end else begin
			rsp_valid <= cmd_valid;
			if (cmd_valid) begin
				rsp_known <= is_pack || is_cell;
				rsp_data <= rsp_nxt;
			end
		end
	end

	// ========================================
	// eeprom access scheduling
	wire done_evt = (done_s != done_seen_r);
	wire launch_boot = !eeprom_access_active_out && boot_pend_r;
	// history stores arriving while busy are dropped; the core retries
	wire launch_store = !eeprom_access_active_out && !boot_pend_r && store_req;
	wire launch = launch_boot || launch_store;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			boot_pend_r <= 1'b1;
			req_tgl_r <= 1'b0;
			req_r <= '0;
			eeprom_access_active_out <= 1'b0;
			done_seen_r <= 1'b0;
			cfg_r <= psea_pkg::CFG_RST;
			eeprom_ack_err <= 1'b0;
		end else begin
			done_seen_r <= done_s;
			if (launch_boot) begin
				boot_pend_r <= 1'b0;
				req_r <= '{wr: 1'b0, addr: psea_pkg::EE_PACK_CFG_ADDR, data: 8'h00};
			end else if (full_reset_req) begin
				boot_pend_r <= 1'b1;
			end
			if (launch_store) begin
				req_r <= '{wr: 1'b1, addr: store_addr, data: store_data};
			end
			if (launch) begin
				req_tgl_r <= ~req_tgl_r;
				eeprom_access_active_out <= 1'b1;
			end else if (done_evt) begin
				eeprom_access_active_out <= 1'b0;
				eeprom_ack_err <= link_ack_err;
				// read data is stable: the link is idle until the next toggle
				if (!req_r.wr && !link_ack_err) begin
					cfg_r <= link_rd_data;
				end
			end
		end
	end

	// ========================================
	// link domain
	psea_sync u_rst (.clk(eeprom_clk), .d(sys_rst), .q(link_rst));
	psea_sync u_done (.clk(clk), .d(link_done_tgl), .q(done_s));

	psea_eep_master u_link (
		.link_clk(eeprom_clk),
		.link_rst(link_rst),
		.req_tgl(req_tgl_r),
		.req(req_r),
		.done_tgl(link_done_tgl),
		.rd_data(link_rd_data),
		.ack_err(link_ack_err),
		.scl(eeprom_clock_line),
		.sda_o(eeprom_data_line_o),
		.sda_oe(eeprom_data_line_oe),
		.sda_i(eeprom_data_line_i)
	);
endmodule : psea_pack_status

// ---- hdl/psea_pkg.sv ----
package psea_pkg;
	// ========================================
	// command codes and eeprom locations
	localparam logic [7:0] CMD_PACK_WORD = 8'h2f;
	localparam logic [7:0] CMD_CELL4 = 8'h3c;
	localparam logic [7:0] CMD_CELL1 = 8'h3f;
	localparam logic [7:0] EE_PACK_CFG_ADDR = 8'h3f;
	localparam logic [7:0] EE_DEV_WR = 8'ha0;
	localparam logic [7:0] EE_DEV_RD = 8'ha1;
	localparam logic [7:0] EE_RX_FILL = 8'hff;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] WORD_NONE = 16'h0000;

	// ========================================
	// two-wire sequencing
	localparam logic [1:0] PH_HI = 2'h1;
	localparam logic [1:0] PH_MID = 2'h2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [2:0] STEP_RESTART = 3'h3;
	localparam logic [2:0] STEP_RX = 3'h5;
	localparam logic [2:0] STEP_RD_STOP = 3'h6;
	localparam logic [2:0] STEP_WR_STOP = 3'h4;

	typedef enum logic [1:0] {LK_IDLE, LK_START, LK_BYTE, LK_STOP} psea_link_st_t;

	// ========================================
	// carriers
	typedef struct packed {
		logic offset_cancel_flag;
		logic end_of_discharge_flag;
		logic charge_activity_flag;
		logic valid_discharge_flag;
		logic charge_fet_state;
		logic discharge_fet_state;
		logic overvoltage_flag;
		logic undervoltage_flag;
	} psea_stat_t;

	typedef struct packed {
		logic [15:0] pack_ov_mv;
		logic [15:0] eod_mv;
		logic [15:0] cell_hi_mv;
		logic [15:0] cell_lo_mv;
	} psea_limits_t;

	typedef logic [3:0][15:0] psea_cells_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} psea_eep_req_t;

	// ========================================
	// any cell beyond a limit
	function automatic logic cells_cmp(input psea_cells_t c, input logic [15:0] lim, input logic above);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			hit = hit | (above ? (c[i] > lim) : (c[i] < lim));
		end
		return hit;
	endfunction : cells_cmp

	// token kind of a sequence step
	function automatic psea_link_st_t step_kind(input logic wr, input logic [2:0] step);
		if (step == 3'h0 || (!wr && step == STEP_RESTART)) begin
			return LK_START;
		end
		if (step == (wr ? STEP_WR_STOP : STEP_RD_STOP)) begin
			return LK_STOP;
		end
		return LK_BYTE;
	endfunction : step_kind
endpackage : psea_pkg

// ---- hdl/psea_sync.sv ----
`timescale 1ns/1ns
module psea_sync (
	input wire logic clk,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// first stage feeds the second only
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule : psea_sync

// ---- hdl/psea_eep_master.sv ----
`timescale 1ns/1ns
module psea_eep_master (
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic req_tgl,
	input wire psea_pkg::psea_eep_req_t req,
	output logic done_tgl,
	output logic [7:0] rd_data,
	output logic ack_err,
	output logic scl,
	output logic sda_o,
	output logic sda_oe,
	input wire logic sda_i
);
	// ========================================
	// crossings into the link domain
	logic req_s;
	logic sda_s;
	logic req_seen_r;
	psea_sync u_req (.clk(link_clk), .d(req_tgl), .q(req_s));
	psea_sync u_sda (.clk(link_clk), .d(sda_i), .q(sda_s));

	psea_pkg::psea_link_st_t st_r;
	logic [2:0] step_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] rx_r;

	wire start_w = (st_r == psea_pkg::LK_IDLE) && (req_s != req_seen_r);
	wire tok_end = (ph_r == psea_pkg::PH_LAST) && (st_r != psea_pkg::LK_BYTE || bit_r == psea_pkg::BIT_ACK);
	wire [2:0] step_nxt = step_r + 3'h1;
	wire [7:0] byte_nxt = (step_nxt == 3'h1) ? psea_pkg::EE_DEV_WR :
		(step_nxt == 3'h2) ? req.addr :
		(step_nxt == 3'h3) ? req.data :
		(step_nxt == 3'h4) ? psea_pkg::EE_DEV_RD : psea_pkg::EE_RX_FILL;
	// ack slot and final nack both leave the line released
	wire tx_bit = (bit_r == psea_pkg::BIT_ACK) | sh_r[7];

	// ========================================
	// bit engine, four link cycles per bit
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			st_r <= psea_pkg::LK_IDLE;
			step_r <= 3'h0;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rx_r <= 8'h00;
			req_seen_r <= 1'b0;
			done_tgl <= 1'b0;
			rd_data <= 8'h00;
			ack_err <= 1'b0;
			scl <= 1'b1;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_w) begin
			req_seen_r <= req_s;
			st_r <= psea_pkg::LK_START;
			step_r <= 3'h0;
			ph_r <= 2'h0;
			ack_err <= 1'b0;
		end else if (st_r != psea_pkg::LK_IDLE) begin
			ph_r <= ph_r + 2'h1;
			unique case (st_r)
				psea_pkg::LK_START: begin
					scl <= (ph_r == 2'h0) || (ph_r == psea_pkg::PH_HI) || (ph_r == psea_pkg::PH_MID);
					sda_oe <= (ph_r == psea_pkg::PH_MID) || (ph_r == psea_pkg::PH_LAST);
				end
				psea_pkg::LK_STOP: begin
					scl <= (ph_r != 2'h0);
					sda_oe <= (ph_r == 2'h0) || (ph_r == psea_pkg::PH_HI);
				end
				psea_pkg::LK_BYTE: begin
					// data moves in ph0 while the clock is still low
					scl <= (ph_r == psea_pkg::PH_HI) || (ph_r == psea_pkg::PH_MID);
					if (ph_r == 2'h0) begin
						sda_oe <= ~tx_bit;
					end
					if (ph_r == psea_pkg::PH_LAST) begin
						bit_r <= bit_r + 4'h1;
						sh_r <= {sh_r[6:0], 1'b1};
						if (bit_r != psea_pkg::BIT_ACK) begin
							rx_r <= {rx_r[6:0], sda_s};
						end else if (step_r == psea_pkg::STEP_RX) begin
							rd_data <= rx_r;
						end else if (sda_s) begin
							ack_err <= 1'b1;
						end
					end
				end
				default: begin
					scl <= 1'b1;
				end
			endcase
			// conventional order: start, device, address, then data and stop, or restart, device, read and stop
			if (tok_end) begin
				bit_r <= 4'h0;
				sh_r <= byte_nxt;
				if (st_r == psea_pkg::LK_STOP) begin
					st_r <= psea_pkg::LK_IDLE;
					done_tgl <= ~done_tgl;
				end else begin
					st_r <= psea_pkg::step_kind(req.wr, step_nxt);
					step_r <= step_nxt;
				end
			end
		end
	end
endmodule : psea_eep_master

// ---- tb/psea_eeprom_model.sv ----
`timescale 1ns/1ns
module psea_eeprom_model #(
	parameter logic [7:0] CFG = 8'h5a
) (
	input wire logic scl,
	input wire logic sda,
	output logic pull
);
	logic [7:0] mem [256];
	logic [7:0] sh, dev, ptr;
	int cnt, nb;
	logic rdm;
	initial begin
		pull = 1'b0;
		cnt = 0;
		nb = 0;
		rdm = 1'b0;
		foreach (mem[i]) mem[i] = 8'hff;
		mem[8'h3e] = 8'h00;
		mem[8'h3f] = CFG;
	end
	// ========================================
	// start or repeated start re-frames the transfer
	always @(negedge sda) if (scl === 1'b1) begin
		cnt = 0;
		nb = 0;
		rdm = 1'b0;
		pull = 1'b0;
	end
	always @(posedge scl) begin
		if (!rdm) sh = {sh[6:0], sda};
		cnt++;
	end
	// no hold time beyond the falling clock edge
	always @(negedge scl) begin
		if (cnt == 8 && !rdm) begin
			if (nb == 0) dev = sh;
			else if (nb == 1) ptr = sh;
			else mem[ptr++] = sh;
			nb++;
			pull = 1'b1;
		end else if (cnt == 8) begin
			pull = 1'b0;
		end else if (cnt == 9) begin
			cnt = 0;
			pull = 1'b0;
			rdm = !rdm && nb == 1 && dev == 8'ha1;
		end
		if (rdm && cnt < 8) pull = ~mem[ptr][7 - cnt];
	end
endmodule : psea_eeprom_model

// ---- tb/psea_pack_status_assertions.sv ----
`timescale 1ns/1ns
module psea_pack_status_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic store_req,
	input wire logic full_reset_req,
	input wire logic rsp_valid,
	input wire logic rsp_known,
	input wire logic [15:0] rsp_data,
	input wire logic charge_fet_control_out,
	input wire logic discharge_fet_control_out,
	input wire logic eeprom_access_active_out,
	input wire logic eeprom_clock_line,
	input wire logic eeprom_data_line_o,
	input wire logic eeprom_data_line_oe
);
	// ========================================
	// one domain, so one default clocking
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rsp_after_cmd: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
	a_rsp_no_extra: assert property (!cmd_valid |=> !rsp_valid) else $error("stray answer");
	a_known_codes: assert property (rsp_valid |-> rsp_known == ($past(cmd_code) == 8'h2f ||
		$past(cmd_code) inside {[8'h3c:8'h3f]})) else $error("bad known flag");
	a_fet_bits_mirror: assert property (rsp_valid && $past(cmd_code) == 8'h2f |-> rsp_data[3:2] ==
		{$past(charge_fet_control_out, 2), $past(discharge_fet_control_out, 2)}) else $error("fet bits");
	a_idle_lines_quiet: assert property (!eeprom_access_active_out |-> eeprom_clock_line && !eeprom_data_line_oe)
		else $error("link busy while inactive");
	a_open_drain_low: assert property (!eeprom_data_line_o) else $error("data driven high");
	a_access_bounded: assert property ($rose(eeprom_access_active_out) |-> eeprom_access_active_out[*8]
		##[1:1000] !eeprom_access_active_out) else $error("access length");
	a_store_launch: assert property (store_req && !eeprom_access_active_out && !$past(eeprom_access_active_out)
		&& !full_reset_req && !$past(sys_rst) |=> eeprom_access_active_out) else $error("store lost");
endmodule : psea_pack_status_assertions
bind psea_pack_status psea_pack_status_assertions psea_pack_status_assertions_inst (.clk(clk), .sys_rst(sys_rst),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .store_req(store_req), .full_reset_req(full_reset_req),
	.rsp_valid(rsp_valid), .rsp_known(rsp_known), .rsp_data(rsp_data),
	.charge_fet_control_out(charge_fet_control_out), .discharge_fet_control_out(discharge_fet_control_out),
	.eeprom_access_active_out(eeprom_access_active_out), .eeprom_clock_line(eeprom_clock_line),
	.eeprom_data_line_o(eeprom_data_line_o), .eeprom_data_line_oe(eeprom_data_line_oe));

// ---- tb/psea_pack_status_tb.sv ----
`timescale 1ns/1ns
module psea_pack_status_tb;
	localparam logic [7:0] CFG = 8'h5a; // arbitrary config content
	typedef struct packed {logic [7:0] code; logic kn; logic [15:0] d;} psea_crow_t;
	typedef struct packed {logic [4:0] lv; logic [15:0] pk; logic [15:0] c0; logic [7:0] st;} psea_srow_t;
	logic clk, sys_rst, eeprom_clk, ofs_cal_done, ofs_cancel_en, conv_pulse, discharge_valid, charge_fet_cmd;
	logic discharge_fet_cmd, over_temp, lithium_pack, full_reset_req, store_req, cmd_valid, rsp_valid, rsp_known;
	logic charge_fet_control_out, discharge_fet_control_out, eeprom_access_active_out, eeprom_ack_err;
	logic eeprom_clock_line, eeprom_data_line_o, eeprom_data_line_oe, sda, pull;
	logic [15:0] pack_mv, rsp_data;
	logic [7:0] store_addr, store_data, cmd_code;
	psea_pkg::psea_limits_t limits;
	psea_pkg::psea_cells_t cells;
	int fail_count, cmp_count, cyc;
	psea_crow_t crow [6] = '{'{8'h3c, 1'b1, 16'h0e44}, '{8'h3d, 1'b1, 16'h0e33}, '{8'h3e, 1'b1, 16'h0e22},
		'{8'h3f, 1'b1, 16'h0e11}, '{8'h2e, 1'b0, 16'h0000}, '{8'h40, 1'b0, 16'h0000}};
	psea_srow_t srow [11] = '{'{5'h00, 16'h4000, 16'h0e11, 8'h00}, '{5'h03, 16'h4000, 16'h0e11, 8'h18},
		'{5'h04, 16'h4000, 16'h0e11, 8'h04}, '{5'h00, 16'h3000, 16'h0e11, 8'h40},
		'{5'h00, 16'h3001, 16'h0e11, 8'h00}, '{5'h00, 16'h5001, 16'h0e11, 8'h02},
		'{5'h08, 16'h4000, 16'h0e11, 8'h02}, '{5'h00, 16'h4000, 16'h1001, 8'h02},
		'{5'h00, 16'h4000, 16'h1000, 8'h00}, '{5'h10, 16'h4000, 16'h0bff, 8'h01},
		'{5'h00, 16'h4000, 16'h0bff, 8'h00}};
	// open-drain line with pull-up
	assign sda = ~(eeprom_data_line_oe | pull);
	psea_pack_status psea_pack_status_inst (.clk, .sys_rst, .eeprom_clk, .ofs_cal_done, .ofs_cancel_en,
		.conv_pulse, .discharge_valid, .charge_fet_cmd, .discharge_fet_cmd, .over_temp, .lithium_pack, .pack_mv,
		.limits, .cells, .full_reset_req, .store_req, .store_addr, .store_data, .cmd_valid, .cmd_code, .rsp_valid,
		.rsp_known, .rsp_data, .charge_fet_control_out, .discharge_fet_control_out, .eeprom_access_active_out,
		.eeprom_ack_err, .eeprom_clock_line, .eeprom_data_line_o, .eeprom_data_line_oe, .eeprom_data_line_i(sda));
	psea_eeprom_model #(.CFG(CFG)) psea_eeprom_model_inst (.scl(eeprom_clock_line), .sda(sda), .pull(pull));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		eeprom_clk = 1'b0;
		#7;
		forever #80 eeprom_clk = ~eeprom_clk;
	end
	// ========================================
	// helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task cmd(input logic [7:0] c, input logic kn, input logic [15:0] d);
		cmd_code <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		chk({14'h0, rsp_valid, rsp_known}, {14'h0, 1'b1, kn});
		chk(rsp_data, d);
		@(posedge clk);
	endtask : cmd
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task wait_idle;
		tick(3);
		while (eeprom_access_active_out !== 1'b0) @(posedge clk);
	endtask : wait_idle
	task print_verdict;
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// generous ceiling: four accesses plus tables stay far below
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ========================================
	// sequence
	initial begin
		{sys_rst, ofs_cal_done, ofs_cancel_en, conv_pulse, discharge_valid, charge_fet_cmd} = 6'h20;
		{discharge_fet_cmd, over_temp, lithium_pack, full_reset_req, store_req, cmd_valid} = 6'h00;
		{store_addr, store_data, cmd_code} = 24'h00_0000;
		pack_mv = 16'h4000;
		limits = {16'h5000, 16'h3000, 16'h1000, 16'h0c00};
		cells = {16'h0e44, 16'h0e33, 16'h0e22, 16'h0e11};
		tick(14);
		sys_rst <= 1'b0;
		wait_idle();
		foreach (crow[i]) cmd(crow[i].code, crow[i].kn, crow[i].d);
		foreach (srow[i]) begin
			{lithium_pack, over_temp, discharge_fet_cmd, charge_fet_cmd, discharge_valid} <= srow[i].lv;
			pack_mv <= srow[i].pk;
			cells[0] <= srow[i].c0;
			tick(2);
			@(negedge clk);
			chk({14'h0, charge_fet_control_out, discharge_fet_control_out}, {14'h0, srow[i].lv[1], srow[i].lv[2]});
			@(posedge clk);
			cmd(8'h2f, 1'b1, {CFG, srow[i].st});
		end
		conv_pulse <= 1'b1;
		tick(1);
		conv_pulse <= 1'b0;
		tick(2);
		cmd(8'h2f, 1'b1, {CFG, 8'h20});
		cmd(8'h2f, 1'b1, {CFG, 8'h00});
		ofs_cal_done <= 1'b1;
		tick(1);
		ofs_cal_done <= 1'b0;
		ofs_cancel_en <= 1'b1;
		tick(2);
		cmd(8'h2f, 1'b1, {CFG, 8'h00});
		ofs_cal_done <= 1'b1;
		tick(1);
		ofs_cal_done <= 1'b0;
		tick(2);
		cmd(8'h2f, 1'b1, {CFG, 8'h80});
		ofs_cancel_en <= 1'b0;
		tick(2);
		cmd(8'h2f, 1'b1, {CFG, 8'h00});
		// second request lands while busy and must be dropped
		{store_req, store_addr, store_data} <= {1'b1, 16'h10a5};
		tick(1);
		store_addr <= 8'h11;
		tick(1);
		store_req <= 1'b0;
		@(negedge clk);
		chk({15'h0, eeprom_access_active_out}, 16'h0001);
		wait_idle();
		chk({8'h0, psea_eeprom_model_inst.mem[8'h10]}, 16'h00a5);
		chk({8'h0, psea_eeprom_model_inst.mem[8'h11]}, 16'h00ff);
		chk({15'h0, eeprom_ack_err}, 16'h0000);
		psea_eeprom_model_inst.mem[8'h3f] = 8'h3c;
		full_reset_req <= 1'b1;
		tick(1);
		full_reset_req <= 1'b0;
		wait_idle();
		cmd(8'h2f, 1'b1, 16'h3c00);
		sys_rst <= 1'b1;
		tick(14);
		@(negedge clk);
		chk(rsp_data, 16'h0000);
		chk({14'h0, eeprom_access_active_out, charge_fet_control_out}, 16'h0000);
		@(posedge clk);
		sys_rst <= 1'b0;
		wait_idle();
		cmd(8'h2f, 1'b1, 16'h3c00);
		print_verdict();
	end
endmodule : psea_pack_status_tb
